// ===== switch_mode_ctrl.sv
/*
 * Operating-mode controller of a six-channel high-side switch: mode
 * sequencing, channel source selection, fault latching and the
 * control and status registers on APB.
 * Assumes a PWM block on the same clock supplies per-channel gates,
 * and that pins and fault comparators are asynchronous levels.
 */
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module switch_mode_ctrl #(
   parameter int INIT_CYCLES  = switch_mode_pkg::INIT_CYCLES,
   parameter int BLANK_CYCLES = switch_mode_pkg::BLANK_CYCLES,
   parameter int WD_CYCLES    = switch_mode_pkg::WD_CYCLES
) (
   input  wire logic                                mclk,
   input  wire logic                                sys_rst,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [switch_mode_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                         pwdata,
   output logic [31:0]                              prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic                                wakeResetN,
   input  wire logic [3:0]                          wakeRequest,
   input  wire logic [3:0]                          directControlInputs,
   input  wire logic                                limpHome,
   input  wire logic                                vpwrAbovePor,
   input  wire logic                                vccAbovePor,
   input  wire switch_mode_pkg::fault_t             faultIn,
   input  wire switch_mode_pkg::serialErr_t         serialErr,
   input  wire logic [5:0]                          pwmGate,
   output logic [5:0]                               channelDrive,
   output logic [4:0]                               ocWindowStart,
   output switch_mode_pkg::mode_t                   mode,
   output logic                                     pwmEnable,
   output logic                                     lowOcProfile,
   output logic                                     analogFeedbackEn,
   output logic                                     readoutEnable,
   output logic [3:0]                               readoutSelect,
   output logic                                     faultBlanked,
   output logic                                     initDone,
   output logic                                     deviceStatusFlag,
   output logic                                     registerClearedFlag
);
   localparam int SW = 12 + $bits(switch_mode_pkg::fault_t);
   localparam int IW = $clog2(INIT_CYCLES + 1);
   localparam int BW = $clog2(BLANK_CYCLES + 1);

   logic [SW-1:0]                syncIn;
   logic [SW-1:0]                syncOut;
   logic                         rstbS;
   logic [3:0]                   wakeReqS;
   logic [3:0]                   directS;
   logic                         limpS;
   logic                         vpwrS;
   logic                         vccS;
   switch_mode_pkg::fault_t      faultS;
   logic                         wake;
   logic                         wakePrev;
   logic                         wakeEvent;
   logic                         failLatch;
   logic                         serialCause;
   logic                         stuckSeen;
   logic                         wdTimeout;
   logic                         wdSeqErr;
   logic                         wdRecover;
   logic                         leaveFail;
   logic                         enterFail;
   switch_mode_pkg::mode_t       next_mode;
   logic [5:0]                   onBits;
   logic [3:0]                   inputEnable;
   logic [3:0]                   readoutSel;
   logic [3:0]                   latchedOff;
   logic [3:0]                   restartHold;
   logic [5:0]                   chCtrl;
   logic [5:0]                   chPrev;
   logic [3:0]                   reqPrev;
   logic [IW-1:0]                initCnt;
   logic [BW-1:0]                blankCnt;
   logic                         device_status_flag;
   logic                         register_cleared_flag;
   logic                         setup;
   logic                         wrTake;
   logic                         rdTake;
   logic                         isNormal;
   logic                         isFail;
   logic                         regHold;

   function automatic logic hit(input logic [switch_mode_pkg::ADDR_W-1:0] a,
                                input logic [3:0] reg_addr);
      hit = (a == reg_addr);
   endfunction : hit

   function automatic logic [4:0] rise5(input logic [4:0] now, input logic [4:0] was);
      rise5 = now & ~was;
   endfunction : rise5

   assign syncIn = {wakeResetN, wakeRequest, directControlInputs, limpHome,
                    vpwrAbovePor, vccAbovePor, faultIn};

   pin_sync #(
      .W (SW)
   ) u_pin_sync (
      .clk (mclk),
      .rst (sys_rst),
      .d   (syncIn),
      .q   (syncOut)
   );

   assign {rstbS, wakeReqS, directS, limpS, vpwrS, vccS, faultS} = syncOut;

   assign isNormal = (mode == switch_mode_pkg::MODE_NORMAL);
   assign isFail   = (mode == switch_mode_pkg::MODE_FAIL);
   assign setup    = psel && !penable;
   assign wrTake   = psel && penable && pready && pwrite;
   assign rdTake   = psel && penable && pready && !pwrite;
   assign regHold  = !rstbS || !(isNormal || isFail);

   serial_watchdog #(
      .LIMIT (WD_CYCLES)
   ) u_serial_watchdog (
      .clk        (mclk),
      .rst        (sys_rst),
      .hold       (regHold),
      .failActive (isFail),
      .wrToggle   (wrTake && hit(paddr, switch_mode_pkg::TOGGLE_ADDR)),
      .toggleBit  (pwdata[switch_mode_pkg::TOGGLE_BIT]),
      .timeout    (wdTimeout),
      .seqErr     (wdSeqErr),
      .recover    (wdRecover)
   );

   assign wake        = (|wakeReqS) || rstbS;
   assign wakeEvent   = wake && !wakePrev;
   assign serialCause = wdTimeout || wdSeqErr || serialErr.toggleErr
                        || serialErr.frameErr || serialErr.stuck;
   assign leaveFail   = isFail && wdRecover && !limpS && !serialCause;

   always_comb begin
      if (!vpwrS && !vccS) begin
         next_mode = switch_mode_pkg::MODE_OFF;
      end else if (!wake) begin
         next_mode = switch_mode_pkg::MODE_SLEEP;
      end else if (failLatch && !leaveFail) begin
         next_mode = switch_mode_pkg::MODE_FAIL;
      end else begin
         next_mode = switch_mode_pkg::MODE_NORMAL;
      end
   end

   assign enterFail = isNormal && (next_mode == switch_mode_pkg::MODE_FAIL);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mode     <= switch_mode_pkg::MODE_OFF;
         wakePrev <= 1'b0;
      end else begin
         mode     <= next_mode;
         wakePrev <= wake;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         failLatch <= 1'b0;
         stuckSeen <= 1'b0;
      end else if (wakeEvent) begin
         failLatch <= limpS || serialCause;
         stuckSeen <= serialErr.stuck;
      end else if (limpS || (serialCause && !regHold)) begin
         failLatch <= 1'b1;
         stuckSeen <= stuckSeen || serialErr.stuck;
      end else if (leaveFail) begin
         failLatch <= 1'b0;
         stuckSeen <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         initCnt  <= '0;
         blankCnt <= '0;
      end else if (wakeEvent) begin
         initCnt  <= IW'(INIT_CYCLES);
         blankCnt <= BW'(BLANK_CYCLES);
      end else begin
         if (initCnt != '0) begin
            initCnt <= initCnt - 1'b1;
         end
         if (blankCnt != '0) begin
            blankCnt <= blankCnt - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         onBits      <= '0;
         inputEnable <= '0;
         readoutSel  <= '0;
      end else if (regHold || wakeEvent || enterFail || leaveFail) begin
         onBits      <= '0;
         inputEnable <= '0;
         if (regHold || wakeEvent || leaveFail) begin
            readoutSel <= '0;
         end
      end else if (wrTake && hit(paddr, switch_mode_pkg::CTRL_ADDR)) begin
         if (isNormal) begin
            onBits      <= pwdata[switch_mode_pkg::ON_LSB +: 6];
            inputEnable <= pwdata[switch_mode_pkg::INEN_LSB +: 4];
         end
         readoutSel <= pwdata[switch_mode_pkg::SOA_LSB +: 4];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         device_status_flag <= 1'b0;
         register_cleared_flag <= 1'b0;
      end else if (leaveFail) begin
         device_status_flag <= 1'b1;
         register_cleared_flag <= 1'b1;
      end else if (regHold || wakeEvent) begin
         device_status_flag <= 1'b0;
         register_cleared_flag <= 1'b0;
      end else if (rdTake && hit(paddr, switch_mode_pkg::QSTAT_ADDR)) begin
         register_cleared_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         latchedOff <= '0;
      end else if (!rstbS || wakeEvent) begin
         latchedOff <= '0;
      end else if (isFail && blankCnt == '0) begin
         latchedOff <= latchedOff | faultS.overTemp | faultS.highOc | faultS.severeShort;
      end
   end

   assign restartHold = (blankCnt == '0) ? (faultS.overload | faultS.underVoltage) : 4'h0;

   assign chCtrl = {onBits[5:4], onBits[3:0] | (inputEnable & directS)};

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         channelDrive  <= '0;
         ocWindowStart <= '0;
         chPrev        <= '0;
         reqPrev       <= '0;
      end else begin
         chPrev  <= isNormal ? chCtrl : 6'h00;
         reqPrev <= wakeReqS;
         unique case (mode)
            switch_mode_pkg::MODE_NORMAL: begin
               channelDrive  <= chCtrl & pwmGate;
               ocWindowStart <= rise5(chCtrl[4:0], chPrev[4:0]);
            end
            switch_mode_pkg::MODE_FAIL: begin
               channelDrive  <= {2'b00, directS & ~latchedOff & ~restartHold};
               ocWindowStart <= rise5({1'b0, wakeReqS}, {1'b0, reqPrev});
            end
            switch_mode_pkg::MODE_OFF, switch_mode_pkg::MODE_SLEEP: begin
               channelDrive  <= '0;
               ocWindowStart <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pwmEnable        <= 1'b0;
         lowOcProfile     <= 1'b0;
         analogFeedbackEn <= 1'b0;
         readoutEnable    <= 1'b0;
         readoutSelect    <= '0;
         faultBlanked     <= 1'b0;
         initDone         <= 1'b0;
         deviceStatusFlag    <= 1'b0;
         registerClearedFlag <= 1'b0;
      end else begin
         pwmEnable        <= isNormal;
         lowOcProfile     <= isFail;
         analogFeedbackEn <= isNormal;
         readoutEnable    <= vccS && (isNormal || (isFail && !stuckSeen));
         readoutSelect    <= readoutSel;
         faultBlanked     <= (blankCnt != '0);
         initDone         <= (isNormal || isFail) && initCnt == '0;
         deviceStatusFlag    <= device_status_flag;
         registerClearedFlag <= register_cleared_flag;
      end
   end

   // The slave answers with no wait state; unmapped addresses give an error.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !(hit(paddr, switch_mode_pkg::CTRL_ADDR)
                    || hit(paddr, switch_mode_pkg::TOGGLE_ADDR)
                    || hit(paddr, switch_mode_pkg::STATUS_ADDR)
                    || hit(paddr, switch_mode_pkg::QSTAT_ADDR));
         prdata  <= '0;
         if (setup && !pwrite) begin
            if (hit(paddr, switch_mode_pkg::CTRL_ADDR)) begin
               prdata[switch_mode_pkg::ON_LSB +: 6]   <= onBits;
               prdata[switch_mode_pkg::INEN_LSB +: 4] <= inputEnable;
               prdata[switch_mode_pkg::SOA_LSB +: 4]  <= readoutSel;
            end else if (hit(paddr, switch_mode_pkg::STATUS_ADDR)
                         || hit(paddr, switch_mode_pkg::QSTAT_ADDR)) begin
               prdata[switch_mode_pkg::ST_MODE_LSB +: 4]  <= mode;
               prdata[switch_mode_pkg::ST_DSF]            <= device_status_flag;
               prdata[switch_mode_pkg::ST_RCF]            <= register_cleared_flag;
               prdata[switch_mode_pkg::ST_SERFAIL]        <= failLatch;
               prdata[switch_mode_pkg::ST_DIAG]           <= !stuckSeen;
               prdata[switch_mode_pkg::ST_INIT]           <= (initCnt == '0);
               prdata[switch_mode_pkg::ST_LATCH_LSB +: 4] <= latchedOff;
            end
         end
      end
   end
endmodule : switch_mode_ctrl

// ===== switch_mode_pkg.sv
/*
 * Constants, types and register map of the operating-mode controller.
 * Assumes a 100 MHz logic clock and a 32-bit APB register port.
 */
// Notes on behaviour
// - Wake is OR of requests and pin.
// - Fail is serial failure or limp-home.
// - Both supplies below threshold means power-off.
// - Sleep keeps logic idle, outputs off.
// - Stay in sleep until wake asserts.
// - Normal exactly when wake and no fail.
// - Normal: on bits or enabled direct inputs.
// - Rising channel control starts overcurrent window, channels 1-5 only.
// - Fail: direct inputs drive 1-4, 5-6 off.
// - Fail ignores control writes, diagnosis stays selectable.
// - Fail selects low overcurrent profile.
// - Fail: overload or undervoltage auto-restarts output.
// - Fail: severe faults latch output off.
// - Fail: windows timed from wake requests.
// - Wake-up clears registers and blanks faults.
// - Initialization completes about 50 us later.
// - Entering fail clears on bits and input enables, keeps readout select and status.
// - Diagnosis lost only for stuck data lines.
// - Leave fail: cause gone, toggles 0 then 1.
// - Fail-to-normal clears registers, sets both flags.
// - Reading quick status clears register-cleared flag.
// - Readout driven only with logic supply present.
// - Reset pin low holds registers in reset.
package switch_mode_pkg;
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  CTRL_ADDR     = 4'h0;
   localparam logic [3:0]  TOGGLE_ADDR   = 4'h4;
   localparam logic [3:0]  STATUS_ADDR   = 4'h8;
   localparam logic [3:0]  QSTAT_ADDR    = 4'hc;
   localparam int          ON_LSB        = 0;
   localparam int          INEN_LSB      = 8;
   localparam int          SOA_LSB       = 12;
   localparam int          TOGGLE_BIT    = 0;
   localparam int          ST_MODE_LSB   = 0;
   localparam int          ST_DSF        = 4;
   localparam int          ST_RCF        = 5;
   localparam int          ST_SERFAIL    = 6;
   localparam int          ST_DIAG       = 7;
   localparam int          ST_INIT       = 8;
   localparam int          ST_LATCH_LSB  = 9;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          INIT_TIME_NS  = 50000;
   localparam int          BLANK_TIME_NS = 20000;
   localparam int          WD_TIME_NS    = 1000000;
   localparam int          INIT_CYCLES   = INIT_TIME_NS / CLK_PERIOD_NS;
   localparam int          BLANK_CYCLES  = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          WD_CYCLES     = WD_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      MODE_OFF    = 4'b0001,
      MODE_SLEEP  = 4'b0010,
      MODE_NORMAL = 4'b0100,
      MODE_FAIL   = 4'b1000
   } mode_t;

   typedef struct packed {
      logic [3:0] overload;
      logic [3:0] underVoltage;
      logic [3:0] overTemp;
      logic [3:0] highOc;
      logic [3:0] severeShort;
   } fault_t;

   typedef struct packed {
      logic toggleErr;
      logic frameErr;
      logic stuck;
   } serialErr_t;
endpackage : switch_mode_pkg

// ===== pin_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous pin levels.
 * Assumes the inputs are levels that stay stable for several clocks.
 */
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : pin_sync

// ===== serial_watchdog.sv
/*
 * Watchdog on the toggle bit of toggle-register writes, with fail recovery.
 * Assumes write strobes are one-cycle pulses on the same clock.
 */
`timescale 1ns/100ps
module serial_watchdog #(
   parameter int LIMIT = 100000
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic hold,
   input  wire logic failActive,
   input  wire logic wrToggle,
   input  wire logic toggleBit,
   output logic      timeout,
   output logic      seqErr,
   output logic      recover
);
   localparam int CW = $clog2(LIMIT + 1);
   logic [CW-1:0] cnt;
   logic          lastBit;
   logic          armed;
   logic          expired;

   assign expired = (cnt == CW'(LIMIT));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (hold || wrToggle) begin
         cnt <= '0;
      end else if (!expired) begin
         cnt <= cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timeout <= 1'b0;
         seqErr  <= 1'b0;
         lastBit <= 1'b1;
      end else begin
         timeout <= !hold && !failActive && !wrToggle && cnt == CW'(LIMIT - 1);
         seqErr  <= !hold && !failActive && wrToggle && toggleBit == lastBit;
         if (hold) begin
            lastBit <= 1'b1;
         end else if (wrToggle) begin
            lastBit <= toggleBit;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armed   <= 1'b0;
         recover <= 1'b0;
      end else begin
         recover <= failActive && !hold && wrToggle && toggleBit && armed && !expired;
         // A toggle write restarts the watchdog cycle, so it may arm even after expiry.
         if (hold || !failActive) begin
            armed <= 1'b0;
         end else if (wrToggle) begin
            armed <= !toggleBit;
         end else if (expired) begin
            armed <= 1'b0;
         end
      end
   end
endmodule : serial_watchdog

// ===== switch_mode_ctrl_properties.sv
/* Concurrent checks on the mode controller ports.
   Assumes a bind into switch_mode_ctrl on its one clock. */
`timescale 1ns/100ps
module switch_mode_ctrl_properties (
   input wire logic                   mclk,
   input wire logic                   sys_rst,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pready,
   input wire logic                   wakeResetN,
   input wire logic [3:0]             wakeRequest,
   input wire logic [3:0]             directControlInputs,
   input wire logic                   limpHome,
   input wire logic                   vpwrAbovePor,
   input wire logic                   vccAbovePor,
   input wire logic [5:0]             channelDrive,
   input wire switch_mode_pkg::mode_t mode,
   input wire logic                   pwmEnable,
   input wire logic                   lowOcProfile,
   input wire logic                   analogFeedbackEn
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_inFail;
      (mode == switch_mode_pkg::MODE_FAIL) [*2];
   endsequence
   a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
      else $error("ready not one cycle");
   a_off_mode: assert property (
      (!vpwrAbovePor && !vccAbovePor) [*4] |=> mode == switch_mode_pkg::MODE_OFF)
      else $error("not off");
   a_sleep_idle: assert property (
      (!wakeResetN && wakeRequest == 4'h0 && vpwrAbovePor) [*4]
      |=> mode == switch_mode_pkg::MODE_SLEEP)
      else $error("not asleep");
   a_limp_fail: assert property (
      (limpHome && wakeResetN && vpwrAbovePor) [*4] |=> mode == switch_mode_pkg::MODE_FAIL)
      else $error("limp not failing");
   a_sleep_dark: assert property (
      (mode == switch_mode_pkg::MODE_SLEEP) [*2] |-> channelDrive == 6'h00 && !pwmEnable)
      else $error("drive in sleep");
   a_fail_upper: assert property (
      s_inFail |-> channelDrive[5:4] == 2'h0 && !pwmEnable && !analogFeedbackEn)
      else $error("upper drive in fail");
   a_fail_profile: assert property (s_inFail |-> lowOcProfile)
      else $error("no low profile");
   a_fail_follow: assert property (
      (mode == switch_mode_pkg::MODE_FAIL && $stable(directControlInputs)) [*4]
      |-> channelDrive[3:0] == directControlInputs)
      else $error("drive not following inputs");
endmodule : switch_mode_ctrl_properties

bind switch_mode_ctrl switch_mode_ctrl_properties props (
   .mclk                (mclk),
   .sys_rst             (sys_rst),
   .psel                (psel),
   .penable             (penable),
   .pready              (pready),
   .wakeResetN          (wakeResetN),
   .wakeRequest         (wakeRequest),
   .directControlInputs (directControlInputs),
   .limpHome            (limpHome),
   .vpwrAbovePor        (vpwrAbovePor),
   .vccAbovePor         (vccAbovePor),
   .channelDrive        (channelDrive),
   .mode                (mode),
   .pwmEnable           (pwmEnable),
   .lowOcProfile        (lowOcProfile),
   .analogFeedbackEn    (analogFeedbackEn)
);

// ===== mcu_pin_model.sv
/* Pin side of the controlling microcontroller.
   Assumes the bench owns the register bus and calls setPins. */
`timescale 1ns/100ps
module mcu_pin_model (
   input  wire logic  mclk,
   input  wire logic  supplyGood,
   output logic       wakeResetN,
   output logic [3:0] wakeRequest,
   output logic [3:0] directControlInputs,
   output logic       limpHome
);
   initial begin
      wakeResetN = 1'b0;
      wakeRequest = 4'h0;
      directControlInputs = 4'h0;
      limpHome = 1'b0;
   end
   task automatic setPins(input logic rstN, input logic [3:0] req, input logic [3:0] din,
                          input logic limp);
      if (rstN)
         wait (supplyGood === 1'b1);
      @(posedge mclk);
      wakeResetN <= rstN;
      wakeRequest <= req;
      directControlInputs <= din;
      limpHome <= limp;
   endtask : setPins
endmodule : mcu_pin_model

// ===== testbench.sv
/* Self-checking bench for the operating-mode controller.
   Assumes the package, pin model and checker compile first. */
`timescale 1ns/100ps
module testbench;
   // Short counts keep the run brief.
   localparam int INIT = 20;
   localparam int BLANK = 20;
   localparam int WD = 400;
   logic                        mclk = 1'b0, sys_rst = 1'b1, err, tgl = 1'b0;
   logic                        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic                        vpwrAbovePor = 1'b1, vccAbovePor = 1'b1, wakeResetN, limpHome;
   logic                        pwmEnable, lowOcProfile, analogFeedbackEn, readoutEnable;
   logic                        faultBlanked, initDone, deviceStatusFlag, registerClearedFlag;
   logic [3:0]                  paddr = 4'h0, wakeRequest, directControlInputs, readoutSelect;
   logic [4:0]                  ocWindowStart, winSeen = 5'h00;
   logic [5:0]                  pwmGate = 6'h3f, channelDrive;
   logic [31:0]                 pwdata = 32'h0, prdata, rd;
   switch_mode_pkg::mode_t      mode;
   switch_mode_pkg::fault_t     faultIn = '0;
   switch_mode_pkg::serialErr_t serialErr = '0;
   int                          failCount = 0, compares = 0, cycles = 0;

   switch_mode_ctrl #(.INIT_CYCLES(INIT), .BLANK_CYCLES(BLANK), .WD_CYCLES(WD)) dut (.*);
   mcu_pin_model pins (.mclk(mclk), .supplyGood(vpwrAbovePor & vccAbovePor),
      .wakeResetN(wakeResetN), .wakeRequest(wakeRequest),
      .directControlInputs(directControlInputs), .limpHome(limpHome));

   always #5 mclk = ~mclk;

   // Collects every overcurrent window pulse seen so far.
   always @(posedge mclk) winSeen <= winSeen | ocWindowStart;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         failCount++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failCount++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic kick();
      apb(1'b1, switch_mode_pkg::TOGGLE_ADDR, {31'h0, tgl});
      tgl = ~tgl;
   endtask : kick

   task automatic waitn(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : waitn

   task automatic supply(input logic v, input logic c);
      @(posedge mclk);
      vpwrAbovePor <= v;
      vccAbovePor <= c;
   endtask : supply

   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      waitn(6);
      check(mode, switch_mode_pkg::MODE_SLEEP);
      check(channelDrive, 6'h00);
      supply(1'b1, 1'b0);
      waitn(6);
      check(mode, switch_mode_pkg::MODE_SLEEP);
      supply(1'b0, 1'b0);
      waitn(6);
      check(mode, switch_mode_pkg::MODE_OFF);
      supply(1'b1, 1'b1);
      pins.setPins(1'b1, 4'h0, 4'h3, 1'b0);
      waitn(5);
      check(mode, switch_mode_pkg::MODE_NORMAL);
      check(initDone, 1'b0);
      check(faultBlanked, 1'b1);
      waitn(INIT + 5);
      check(initDone, 1'b1);
      check(faultBlanked, 1'b0);
      apb(1'b0, switch_mode_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h0);
      kick();
      apb(1'b1, switch_mode_pkg::CTRL_ADDR, 32'h5130);
      waitn(5);
      check(channelDrive, 6'h31);
      check(winSeen, 5'h11);
      waitn(WD + 20);
      check(mode, switch_mode_pkg::MODE_FAIL);
      check(channelDrive, 6'h03);
      check(lowOcProfile, 1'b1);
      check(readoutEnable, 1'b1);
      apb(1'b0, switch_mode_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h5000);
      apb(1'b1, switch_mode_pkg::CTRL_ADDR, 32'h503f);
      apb(1'b0, switch_mode_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h5000);
      check(readoutSelect, 4'h5);
      pins.setPins(1'b1, 4'h0, 4'ha, 1'b0);
      waitn(5);
      check(channelDrive, 6'h0a);
      tgl = 1'b0;
      kick();
      kick();
      waitn(5);
      check(mode, switch_mode_pkg::MODE_NORMAL);
      check({deviceStatusFlag, registerClearedFlag}, 2'h3);
      apb(1'b0, switch_mode_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, switch_mode_pkg::STATUS_ADDR, 32'h0);
      check(registerClearedFlag, 1'b1);
      apb(1'b0, switch_mode_pkg::QSTAT_ADDR, 32'h0);
      waitn(1);
      check(registerClearedFlag, 1'b0);
      apb(1'b0, 4'h2, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      pins.setPins(1'b1, 4'h0, 4'h0, 1'b1);
      waitn(5);
      check(mode, switch_mode_pkg::MODE_FAIL);
      pins.setPins(1'b0, 4'h4, 4'h0, 1'b0);
      waitn(5);
      check(mode == switch_mode_pkg::MODE_SLEEP, 1'b0);
      pins.setPins(1'b0, 4'h0, 4'h0, 1'b0);
      waitn(5);
      check(mode, switch_mode_pkg::MODE_SLEEP);
      print_verdict();
   end
endmodule : testbench
